// *** src/cipc_input_path_ctrl.sv ***
/*
 * Input path control register bank of a mono codec, written by a host
 * over a 2-wire or 3-wire serial control link chosen by a strap pin.
 * Assumes link pins are asynchronous to sys_clk and much slower than it
 * (link clock period 200 ns or more); the shared data pin is open drain.
 */
// Overview of operation
// - Strap high selects 3-wire control link, strap low selects 2-wire link.
// - In 2-wire mode act only as target at fixed address 0011010.
// - Disabled ADC or DAC logic is frozen in its last enabled state.
// - Four-signal audio port supports I2S, DSP, left and right justified.
// - Audio port is clock master driving bit/frame clocks, or clock slave.
// - PLL may make the master clock, else drive clocks out on clock pin.
// - Routing bit 2, reset 0, connects aux amplifier to amp negative input.
// - Routing bit 1, reset 1, connects inverting mic pin to amp negative.
// - Routing bit 0, reset 0, picks mid-rail (0) or non-inverting mic (1).
// - Power management two bit 2, reset 0, enables the input mic amp.
// - Input amplifier gain programmable from -12 dB to +35.25 dB.
// - Boost stage after the input amp adds up to 20 dB more gain.
// - Converter filtering supports sample rates from 8 to 48 ks/s.
// - ADC path has one high-pass filter and four notch filters.
// - Each unused circuit section can be powered down by software; here only the input amp has one (power management two bit 2).
`timescale 1ns/100ps

module cipc_input_path_ctrl (
	// Clock and reset
	input  wire logic       sys_clk,
	input  wire logic       resetn,
	// Control link pins
	input  wire logic       mode_strap,
	input  wire logic       ctrl_sclk,
	input  wire logic       ctrl_csb,
	input  wire logic       ctrl_sdin_in,
	output logic            ctrl_sdin_out,
	output logic            ctrl_sdin_oe,
	// Converter and clocking controls from the rest of the chip
	input  wire logic       adc_enable,
	input  wire logic       dac_enable,
	input  wire logic [1:0] aif_format,
	input  wire logic       aif_master,
	input  wire logic       pll_select,
	// Analogue routing and power controls
	output logic            aux_to_amp_neg,
	output logic            inv_mic_to_amp_neg,
	output logic            amp_pos_source_sel,
	output logic            input_amp_enable,
	// Converter hold and audio port controls
	output logic            adc_logic_hold,
	output logic            dac_logic_hold,
	output logic            aif_clocks_oe,
	output logic [1:0]      aif_format_sel,
	output logic            mclk_from_pll,
	output logic            clock_output_pin_en,
	// Status
	output logic            link_is_3wire
);

	// Reset release
	logic rst_meta_ff;
	logic rst_n_ff;

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			rst_meta_ff <= 1'b0;
			rst_n_ff    <= 1'b0;
		end else begin
			rst_meta_ff <= 1'b1;
			rst_n_ff    <= rst_meta_ff;
		end
	end

	// Pin synchronisers, two flops per lane
	logic [cipc_pkg::SYNC_LANES-1:0] pin_raw;
	logic [cipc_pkg::SYNC_LANES-1:0] pin_meta_ff;
	logic [cipc_pkg::SYNC_LANES-1:0] pin_sync_ff;

	assign pin_raw[cipc_pkg::LANE_STRAP] = mode_strap;
	assign pin_raw[cipc_pkg::LANE_SCLK]  = ctrl_sclk;
	assign pin_raw[cipc_pkg::LANE_SDIN]  = ctrl_sdin_in;
	assign pin_raw[cipc_pkg::LANE_CSB]   = ctrl_csb;

	genvar gi;
	generate
		for (gi = 0; gi < cipc_pkg::SYNC_LANES; gi++) begin : g_sync
			always_ff @(posedge sys_clk or negedge rst_n_ff) begin
				if (!rst_n_ff) begin
					pin_meta_ff[gi] <= cipc_pkg::SYNC_RST_VAL[gi];
					pin_sync_ff[gi] <= cipc_pkg::SYNC_RST_VAL[gi];
				end else begin
					pin_meta_ff[gi] <= pin_raw[gi];
					pin_sync_ff[gi] <= pin_meta_ff[gi];
				end
			end
		end
	endgenerate

	// Delayed copies for edge finding
	logic sclk_d_ff;
	logic sdin_d_ff;
	logic csb_d_ff;
	logic mode_3w_ff;

	always_ff @(posedge sys_clk or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			sclk_d_ff  <= 1'b1;
			sdin_d_ff  <= 1'b1;
			csb_d_ff   <= 1'b1;
			mode_3w_ff <= 1'b0;
		end else begin
			sclk_d_ff  <= pin_sync_ff[cipc_pkg::LANE_SCLK];
			sdin_d_ff  <= pin_sync_ff[cipc_pkg::LANE_SDIN];
			csb_d_ff   <= pin_sync_ff[cipc_pkg::LANE_CSB];
			mode_3w_ff <= pin_sync_ff[cipc_pkg::LANE_STRAP];
		end
	end

	logic sclk_s;
	logic sdin_s;
	logic sclk_rise;
	logic sclk_fall;
	logic csb_rise;
	logic tw_start;
	logic tw_stop;

	assign sclk_s    = pin_sync_ff[cipc_pkg::LANE_SCLK];
	assign sdin_s    = pin_sync_ff[cipc_pkg::LANE_SDIN];
	assign sclk_rise = sclk_s & ~sclk_d_ff;
	assign sclk_fall = ~sclk_s & sclk_d_ff;
	assign csb_rise  = pin_sync_ff[cipc_pkg::LANE_CSB] & ~csb_d_ff;
	// Data moving while clock stays high marks start or stop
	assign tw_start  = ~mode_3w_ff & sclk_s & sclk_d_ff & sdin_d_ff & ~sdin_s;
	assign tw_stop   = ~mode_3w_ff & sclk_s & sclk_d_ff & ~sdin_d_ff & sdin_s;

	// 3-wire receiver: shift on clock rise, commit on select rise
	logic [cipc_pkg::WORD_BITS-1:0] tri_shift_ff;

	always_ff @(posedge sys_clk or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			tri_shift_ff <= '0;
		end else if (mode_3w_ff && sclk_rise) begin
			tri_shift_ff <= {tri_shift_ff[cipc_pkg::WORD_BITS-2:0], sdin_s};
		end
	end

	// 2-wire receiver
	cipc_pkg::cipc_tw_state_e tw_state_ff;
	cipc_pkg::cipc_tw_state_e nxt_tw_state;
	logic [cipc_pkg::BYTE_BITS-1:0] tw_shift_ff;
	logic [cipc_pkg::BYTE_BITS-1:0] tw_hi_ff;
	logic [3:0]                     tw_cnt_ff;
	logic                           tw_byte_done;
	logic                           tw_addr_hit;
	logic                           tw_commit;

	assign tw_byte_done = (tw_cnt_ff == 4'(cipc_pkg::BYTE_BITS));
	assign tw_addr_hit  = (tw_shift_ff[cipc_pkg::BYTE_BITS-1:1] == cipc_pkg::TARGET_ADDR) &&
	                      (tw_shift_ff[0] == cipc_pkg::DIR_WRITE);

	always_comb begin
		nxt_tw_state = tw_state_ff;
		if (mode_3w_ff || tw_stop) begin
			nxt_tw_state = cipc_pkg::CIPC_TW_IDLE;
		end else if (tw_start) begin
			nxt_tw_state = cipc_pkg::CIPC_TW_ADDR;
		end else if (sclk_fall) begin
			unique case (tw_state_ff)
				cipc_pkg::CIPC_TW_IDLE: begin
					nxt_tw_state = cipc_pkg::CIPC_TW_IDLE;
				end
				cipc_pkg::CIPC_TW_ADDR: begin
					if (tw_byte_done) begin
						// Foreign address or read request: stay silent
						nxt_tw_state = tw_addr_hit ? cipc_pkg::CIPC_TW_ACK_ADDR
						                           : cipc_pkg::CIPC_TW_IDLE;
					end
				end
				cipc_pkg::CIPC_TW_ACK_ADDR: begin
					nxt_tw_state = cipc_pkg::CIPC_TW_BYTE_HI;
				end
				cipc_pkg::CIPC_TW_BYTE_HI: begin
					if (tw_byte_done) begin
						nxt_tw_state = cipc_pkg::CIPC_TW_ACK_HI;
					end
				end
				cipc_pkg::CIPC_TW_ACK_HI: begin
					nxt_tw_state = cipc_pkg::CIPC_TW_BYTE_LO;
				end
				cipc_pkg::CIPC_TW_BYTE_LO: begin
					if (tw_byte_done) begin
						nxt_tw_state = cipc_pkg::CIPC_TW_ACK_LO;
					end
				end
				cipc_pkg::CIPC_TW_ACK_LO: begin
					nxt_tw_state = cipc_pkg::CIPC_TW_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			tw_state_ff <= cipc_pkg::CIPC_TW_IDLE;
		end else begin
			tw_state_ff <= nxt_tw_state;
		end
	end

	// Bit counter restarts at each new byte; shifter is not cleared, new bits shift through it
	always_ff @(posedge sys_clk or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			tw_cnt_ff   <= '0;
			tw_shift_ff <= '0;
		end else if (tw_start || nxt_tw_state != tw_state_ff) begin
			tw_cnt_ff <= '0;
		end else if (sclk_rise && !tw_byte_done) begin
			tw_cnt_ff   <= tw_cnt_ff + 4'h1;
			tw_shift_ff <= {tw_shift_ff[cipc_pkg::BYTE_BITS-2:0], sdin_s};
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			tw_hi_ff <= '0;
		end else if (tw_state_ff == cipc_pkg::CIPC_TW_BYTE_HI &&
		             nxt_tw_state == cipc_pkg::CIPC_TW_ACK_HI) begin
			tw_hi_ff <= tw_shift_ff;
		end
	end

	assign tw_commit = (tw_state_ff == cipc_pkg::CIPC_TW_BYTE_LO) &&
	                   (nxt_tw_state == cipc_pkg::CIPC_TW_ACK_LO);

	// Acknowledge by pulling data low through the ninth clock
	logic sdin_oe_ff;

	always_ff @(posedge sys_clk or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			sdin_oe_ff <= 1'b0;
		end else begin
			sdin_oe_ff <= (nxt_tw_state == cipc_pkg::CIPC_TW_ACK_ADDR) ||
			              (nxt_tw_state == cipc_pkg::CIPC_TW_ACK_HI) ||
			              (nxt_tw_state == cipc_pkg::CIPC_TW_ACK_LO);
		end
	end

	assign ctrl_sdin_out = 1'b0;
	assign ctrl_sdin_oe  = sdin_oe_ff;

	// Common write port
	logic                           wr_stb;
	logic [cipc_pkg::WORD_BITS-1:0] wr_word;
	logic [cipc_pkg::IDX_BITS-1:0]  wr_idx;
	logic [cipc_pkg::DATA_BITS-1:0] wr_data;

	always_comb begin
		wr_stb  = 1'b0;
		wr_word = {tw_hi_ff, tw_shift_ff};
		if (mode_3w_ff) begin
			wr_stb  = csb_rise;
			wr_word = tri_shift_ff;
		end else begin
			wr_stb  = tw_commit;
		end
	end

	assign wr_idx  = wr_word[cipc_pkg::WORD_BITS-1 -: cipc_pkg::IDX_BITS];
	assign wr_data = wr_word[cipc_pkg::DATA_BITS-1:0];

	// Register bank; unmapped indices are ignored
	logic [cipc_pkg::DATA_BITS-1:0] power_management_two_ff;
	logic [cipc_pkg::DATA_BITS-1:0] input_source_routing_ff;

	always_ff @(posedge sys_clk or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			power_management_two_ff <= cipc_pkg::RST_POWER_MANAGEMENT_TWO;
		end else if (wr_stb && wr_idx == cipc_pkg::IDX_POWER_MANAGEMENT_TWO) begin
			power_management_two_ff <= wr_data;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			input_source_routing_ff <= cipc_pkg::RST_INPUT_SOURCE_ROUTING;
		end else if (wr_stb && wr_idx == cipc_pkg::IDX_INPUT_SOURCE_ROUTING) begin
			input_source_routing_ff <= wr_data;
		end
	end

	assign aux_to_amp_neg     = input_source_routing_ff[cipc_pkg::BIT_AUX_TO_AMP_NEG];
	assign inv_mic_to_amp_neg =
		input_source_routing_ff[cipc_pkg::BIT_INV_MIC_TO_AMP_NEG];
	assign amp_pos_source_sel =
		input_source_routing_ff[cipc_pkg::BIT_AMP_POS_SOURCE_SEL];
	// Amplifier gain range and boost are analogue; only the enable lives here
	assign input_amp_enable   =
		power_management_two_ff[cipc_pkg::BIT_INPUT_AMP_ENABLE];

	// Converter hold and clocking controls, registered for clean levels
	logic                 adc_hold_ff;
	logic                 dac_hold_ff;
	logic                 aif_oe_ff;
	logic [1:0]           aif_fmt_ff;
	logic                 pll_mclk_ff;
	logic                 clock_output_pin_en_ff;

	always_ff @(posedge sys_clk or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			adc_hold_ff <= 1'b1;
			dac_hold_ff <= 1'b1;
		end else begin
			// Hold keeps filter state; clock must still run to flush it
			adc_hold_ff <= ~adc_enable;
			dac_hold_ff <= ~dac_enable;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			aif_oe_ff    <= 1'b0;
			aif_fmt_ff   <= cipc_pkg::CIPC_FMT_I2S;
			pll_mclk_ff  <= 1'b0;
			clock_output_pin_en_ff <= 1'b0;
		end else begin
			aif_oe_ff    <= aif_master;
			aif_fmt_ff   <= aif_format;
			pll_mclk_ff  <= pll_select;
			clock_output_pin_en_ff <= ~pll_select;
		end
	end

	assign adc_logic_hold      = adc_hold_ff;
	assign dac_logic_hold      = dac_hold_ff;
	assign aif_clocks_oe       = aif_oe_ff;
	assign aif_format_sel      = aif_fmt_ff;
	assign mclk_from_pll       = pll_mclk_ff;
	assign clock_output_pin_en = clock_output_pin_en_ff;
	assign link_is_3wire       = mode_3w_ff;

endmodule : cipc_input_path_ctrl

// *** src/cipc_pkg.sv ***
/*
 * Constants shared by the codec input path control block: register
 * indices, field positions, reset values and serial link figures.
 * Assumes a 7-bit register index and 9-bit register data per control word.
 */
package cipc_pkg;

	// Control word layout: 7-bit index then 9-bit data, MSB first
	localparam int unsigned WORD_BITS  = 16;
	localparam int unsigned IDX_BITS   = 7;
	localparam int unsigned DATA_BITS  = 9;
	localparam int unsigned BYTE_BITS  = 8;

	// Register indices
	localparam logic [6:0] IDX_POWER_MANAGEMENT_TWO = 7'h02;
	localparam logic [6:0] IDX_INPUT_SOURCE_ROUTING = 7'h2C;

	// Reset values
	localparam logic [8:0] RST_POWER_MANAGEMENT_TWO = 9'h000;
	localparam logic [8:0] RST_INPUT_SOURCE_ROUTING = 9'h002;

	// Field positions
	localparam int unsigned BIT_INPUT_AMP_ENABLE   = 2;
	localparam int unsigned BIT_AUX_TO_AMP_NEG     = 2;
	localparam int unsigned BIT_INV_MIC_TO_AMP_NEG = 1;
	localparam int unsigned BIT_AMP_POS_SOURCE_SEL = 0;

	// Fixed 2-wire target address and write direction bit
	localparam logic [6:0] TARGET_ADDR = 7'h1A;
	localparam logic       DIR_WRITE   = 1'b0;

	// Synchroniser lanes: strap, serial clock, serial data, select
	localparam int unsigned SYNC_LANES    = 4;
	localparam int unsigned LANE_STRAP    = 0;
	localparam int unsigned LANE_SCLK     = 1;
	localparam int unsigned LANE_SDIN     = 2;
	localparam int unsigned LANE_CSB      = 3;
	localparam logic [3:0]  SYNC_RST_VAL  = 4'hE;

	// Audio port data formats
	typedef enum logic [1:0] {
		CIPC_FMT_RIGHT_JUST,
		CIPC_FMT_LEFT_JUST,
		CIPC_FMT_I2S,
		CIPC_FMT_DSP
	} cipc_fmt_e;

	// 2-wire receive sequence
	typedef enum logic [2:0] {
		CIPC_TW_IDLE,
		CIPC_TW_ADDR,
		CIPC_TW_ACK_ADDR,
		CIPC_TW_BYTE_HI,
		CIPC_TW_ACK_HI,
		CIPC_TW_BYTE_LO,
		CIPC_TW_ACK_LO
	} cipc_tw_state_e;

endpackage : cipc_pkg

// *** verif/cipc_input_path_ctrl_asserts.sv ***
/* Checker for the input path control block.
   Assumes it is bound to cipc_input_path_ctrl and sees its ports only. */
`timescale 1ns/100ps
module cipc_chk (
	// Clock and reset
	input wire logic       sys_clk,
	input wire logic       resetn,
	// Inputs
	input wire logic       mode_strap,
	input wire logic       ctrl_csb,
	input wire logic       adc_enable,
	input wire logic       dac_enable,
	input wire logic       pll_select,
	input wire logic [1:0] aif_format,
	input wire logic       aif_master,
	// Outputs
	input wire logic       ctrl_sdin_oe,
	input wire logic       aux_to_amp_neg,
	input wire logic       inv_mic_to_amp_neg,
	input wire logic       amp_pos_source_sel,
	input wire logic       input_amp_enable,
	input wire logic       adc_logic_hold,
	input wire logic       dac_logic_hold,
	input wire logic       aif_clocks_oe,
	input wire logic [1:0] aif_format_sel,
	input wire logic       mclk_from_pll,
	input wire logic       clock_output_pin_en,
	input wire logic       link_is_3wire
);
	// Design leaves reset two edges after release; wait a little longer
	logic [2:0] settle_ff;
	logic       live;
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn)
			settle_ff <= 3'h0;
		else if (settle_ff != 3'h4)
			settle_ff <= settle_ff + 3'h1;
	end
	assign live = (settle_ff == 3'h4);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!live);

	chk_adc_freeze: assert property (!adc_enable |=> adc_logic_hold)
		else $error("converter logic not held");
	chk_adc_run: assert property (adc_enable ##1 adc_enable |-> !adc_logic_hold)
		else $error("converter logic held while enabled");
	chk_dac_freeze: assert property (!dac_enable |=> dac_logic_hold)
		else $error("converter logic not held");
	chk_dac_run: assert property (dac_enable |=> !dac_logic_hold)
		else $error("converter logic held while enabled");
	chk_pll_follow: assert property (pll_select |=> mclk_from_pll)
		else $error("master clock not taken from pll");
	chk_clock_output_pin_use: assert property (!pll_select |=> clock_output_pin_en)
		else $error("clock pin not enabled with pll free");
	chk_slave_role: assert property ($fell(aif_master) |=> !aif_clocks_oe)
		else $error("audio clocks driven as slave");
	chk_fmt_pass: assert property ($stable(aif_format) |-> aif_format_sel == aif_format)
		else $error("audio format not passed");
	chk_master_role: assert property ($rose(aif_master) |=> aif_clocks_oe)
		else $error("audio clocks not driven as master");
	chk_clk_source: assert property (mclk_from_pll != clock_output_pin_en)
		else $error("pll use and clock pin clash");
	chk_strap_mode: assert property ($stable(mode_strap)[*8] |-> link_is_3wire == mode_strap)
		else $error("link mode does not follow strap");
	chk_ack_two_wire: assert property (ctrl_sdin_oe |-> !link_is_3wire)
		else $error("data pin pulled in 3-wire mode");
	chk_ack_length: assert property ($rose(ctrl_sdin_oe) |-> ctrl_sdin_oe[*5] ##[1:12] !ctrl_sdin_oe)
		else $error("ack pulse length wrong");
	chk_reg_hold: assert property ((link_is_3wire && !ctrl_csb)[*8] |->
		$stable({aux_to_amp_neg, inv_mic_to_amp_neg, amp_pos_source_sel, input_amp_enable}))
		else $error("register changed mid frame");
endmodule : cipc_chk

bind cipc_input_path_ctrl cipc_chk u_chk (.sys_clk, .resetn, .mode_strap, .ctrl_csb,
	.adc_enable, .dac_enable, .pll_select, .aif_format, .aif_master, .ctrl_sdin_oe,
	.aux_to_amp_neg, .inv_mic_to_amp_neg, .amp_pos_source_sel, .input_amp_enable,
	.adc_logic_hold, .dac_logic_hold, .aif_clocks_oe, .aif_format_sel, .mclk_from_pll,
	.clock_output_pin_en, .link_is_3wire);

// *** verif/cipc_host_model.sv ***
/* Host side of the serial control link, 3-wire and 2-wire writes.
   Assumes it is called at a falling sys_clk edge; link clock 200 ns. */
`timescale 1ns/100ps
module cipc_host (
	// Clock
	input wire logic sys_clk,
	// Link pins
	input wire logic sdin,
	output logic     sclk,
	output logic     csb,
	output logic     sda
);
	initial begin
		sclk = 1'b0;
		csb = 1'b1;
		sda = 1'b0;
	end
	task automatic hc(input int n);
		repeat (n) @(negedge sys_clk);
	endtask : hc
	// Index then data, MSB first; commit on select rise
	task automatic w3(input logic [15:0] w);
		csb = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			sclk = 1'b0;
			sda = w[i];
			hc(4);
			sclk = 1'b1;
			hc(4);
		end
		sclk = 1'b0;
		// No pull-up on this line: show the inverse once released
		sda = ~w[0];
		hc(4);
		csb = 1'b1;
		hc(4);
	endtask : w3
	task automatic bit2(input logic b, output logic a);
		sda = b;
		hc(4);
		sclk = 1'b1;
		hc(2);
		a = ~sdin;
		hc(2);
		sclk = 1'b0;
	endtask : bit2
	// Start, three bytes each followed by an ack slot, stop
	task automatic w2(input logic [23:0] b, output logic [2:0] ack);
		logic a;
		sda = 1'b1;
		sclk = 1'b1;
		hc(4);
		sda = 1'b0;
		hc(4);
		sclk = 1'b0;
		for (int i = 23; i >= 0; i--) begin
			bit2(b[i], a);
			if (i % 8 == 0) begin
				bit2(1'b1, a);
				ack[i / 8] = a;
			end
		end
		sda = 1'b0;
		hc(4);
		sclk = 1'b1;
		hc(4);
		sda = 1'b1;
		hc(4);
	endtask : w2
endmodule : cipc_host

// *** verif/cipc_input_path_ctrl_tb_top.sv ***
/* Self-checking bench for the input path control block.
   Assumes the host model drives the link; the data pin is open drain. */
`timescale 1ns/100ps
module cipc_input_path_ctrl_tb_top;
	logic        sys_clk = 1'b0;
	logic        resetn = 1'b0;
	logic        mode_strap = 1'b1;
	logic        adc_enable, dac_enable, aif_master, pll_select;
	logic [1:0]  aif_format;
	wire         sclk, csb, sda, sdin, sdo, oe, l3;
	wire  [3:0]  v;
	wire  [1:0]  fmt_o;
	logic [3:0]  exp_q[$];
	logic [3:0]  exp_v, last_v;
	logic [2:0]  ack3;
	logic [15:0] rnd = 16'h0003;
	logic        mon_on = 1'b0;
	int          bad_count = 0;
	int          n_compared = 0;
	int          cycles = 0;

	// Free running, also after converters stop
	always #12.5 sys_clk = ~sys_clk;
	assign sdin = sda & (oe ? sdo : 1'b1);

	cipc_input_path_ctrl u_dut (.sys_clk, .resetn, .mode_strap, .ctrl_sclk(sclk),
		.ctrl_csb(csb), .ctrl_sdin_in(sdin), .ctrl_sdin_out(sdo), .ctrl_sdin_oe(oe),
		.adc_enable, .dac_enable, .aif_format, .aif_master, .pll_select,
		.aux_to_amp_neg(v[3]), .inv_mic_to_amp_neg(v[2]), .amp_pos_source_sel(v[1]),
		.input_amp_enable(v[0]), .adc_logic_hold(), .dac_logic_hold(),
		.aif_clocks_oe(), .aif_format_sel(fmt_o), .mclk_from_pll(),
		.clock_output_pin_en(), .link_is_3wire(l3));
	cipc_host u_host (.sys_clk, .sdin, .sclk, .csb, .sda);

	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr
	task automatic cmp(input string n, input logic [3:0] e, input logic [3:0] g);
		n_compared++;
		if (g !== e) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask : cmp
	task automatic stop_test;
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : stop_test
	// Note the expected outputs, then send the word
	task automatic wr(input logic [6:0] idx, input logic [8:0] d, input logic two);
		logic [3:0] pv;
		pv = exp_v;
		if (idx == 7'h2C)
			exp_v[3:1] = d[2:0];
		else if (idx == 7'h02)
			exp_v[0] = d[2];
		if (exp_v !== pv)
			exp_q.push_back(exp_v);
		if (two) begin
			u_host.w2({8'h34, idx, d}, ack3);
			cmp("ack", 4'h7, {1'b0, ack3});
		end else
			u_host.w3({idx, d});
	endtask : wr

	always @(negedge sys_clk) begin
		cycles++;
		if (cycles == 20000) begin
			bad_count++;
			stop_test();
		end
		if (mon_on && v !== last_v) begin
			if (exp_q.size() == 0)
				cmp("regs", last_v, v);
			else
				cmp("regs", exp_q.pop_front(), v);
			last_v = v;
		end
	end

	initial begin
		{adc_enable, dac_enable, aif_master, pll_select} = 4'h0;
		aif_format = 2'h0;
		repeat (20) @(negedge sys_clk);
		resetn = 1'b1;
		repeat (12) @(negedge sys_clk);
		cmp("reset", 4'h4, v);
		exp_v = 4'h4;
		last_v = v;
		mon_on = 1'b1;
		for (int i = 0; i < 4; i++) begin
			aif_format = i[1:0];
			repeat (2) @(negedge sys_clk);
			cmp("format", {2'h0, aif_format}, {2'h0, fmt_o});
		end
		// Single-ended mic setting equals the default: no change expected
		wr(7'h2C, 9'h002, 1'b0);
		// Pseudo-differential: positive from non-inverting pin, ground on inverting pin
		wr(7'h2C, 9'h003, 1'b0);
		for (int m = 1; m >= 0; m--) begin
			mode_strap = m[0];
			repeat (10) @(negedge sys_clk);
			cmp("mode", {3'h0, m[0]}, {3'h0, l3});
			for (int i = 0; i < 6; i++) begin
				rnd = lfsr(rnd);
				{adc_enable, dac_enable, aif_master, pll_select} = rnd[12:9];
				wr(i % 3 == 2 ? 7'h05 : (i % 3 == 1 ? 7'h02 : 7'h2C), rnd[8:0], !m[0]);
			end
		end
		// Wrong address, then right address with read direction: refused
		for (int k = 0; k < 2; k++) begin
			u_host.w2({k ? 8'h35 : 8'h36, 7'h2C, 6'h00, ~exp_v[3:1]}, ack3);
			cmp("ack", 4'h0, {1'b0, ack3});
		end
		// Enable the amp so the reset below must visibly restore defaults
		wr(7'h02, 9'h004, 1'b1);
		exp_q.push_back(4'h4);
		exp_v = 4'h4;
		resetn = 1'b0;
		repeat (4) @(negedge sys_clk);
		resetn = 1'b1;
		repeat (12) @(negedge sys_clk);
		cmp("reset", 4'h4, v);
		repeat (20) @(negedge sys_clk);
		cmp("pending", 4'h0, 4'(exp_q.size()));
		stop_test();
	end
endmodule : cipc_input_path_ctrl_tb_top
